// ### prs_pkg.sv
// Package with the register map, field layouts, reset values and timing counts
package prs_pkg;
	localparam int NREF = 4;
	localparam int NPLL = 2;
	localparam int CNT_W = 17;
	localparam int VAL_EDGES = 8;
	localparam int MON_DIV = 8;
	localparam int SYS_MHZ = 40;
	localparam int HIST_MS = 100;
	localparam int HIST_CYC = HIST_MS * 1000 * SYS_MHZ;
	localparam int IIR_MIN = 20;
	localparam int IIR_SHIFT = $clog2(IIR_MIN * 60 * 1000 / HIST_MS);
	// Register byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PRIO = 8'h04;
	localparam logic [7:0] A_CNT0 = 8'h08;
	localparam logic [7:0] A_MAP = 8'h18;
	localparam logic [7:0] A_STAT = 8'h1C;
	localparam logic [7:0] A_EVT = 8'h20;
	localparam logic [7:0] A_MASK = 8'h24;
	// Field positions
	localparam int CFG_STRIDE = 16;
	localparam int PRIO_STRIDE = 8;
	localparam int MAP_HOLD = 16;
	localparam int EVT_HOLD = 4;
	localparam int ST_LOS = 0;
	localparam int ST_SOFT = 4;
	localparam int ST_STATE = 8;
	localparam int ST_SEL = 12;
	localparam int ST_FRZ = 16;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] PRIO_RST = 32'h0000_E4E4;
	localparam logic [CNT_W-1:0] CNT_RST = 17'h0_0100;
	localparam logic [31:0] MAP_RST = 32'h0000_0000;
	// Reference choice modes
	localparam logic [1:0] MODE_REG = 2'h0;
	localparam logic [1:0] MODE_PIN = 2'h1;
	localparam logic [1:0] MODE_AUTO = 2'h2;
	// Holdover frequency sources
	localparam logic [1:0] HO_CENTRE = 2'h0;
	localparam logic [1:0] HO_INST = 2'h1;
	localparam logic [1:0] HO_AVG = 2'h2;
	typedef enum logic [1:0] {ST_FREE, ST_LOCK, ST_HOLD} prs_state_t;
	// Per-PLL control word
	typedef struct packed {
		logic [1:0] hoSrc;
		logic [1:0] phase_slope_rate;
		logic switch_behaviour_select;
		logic revert;
		logic [1:0] manRef;
		logic [1:0] reference_choice_field;
	} prs_cfg_t;
	localparam int CFG_W = $bits(prs_cfg_t);
endpackage

// ### prs_ref_manager.sv
// Reference selection, loss-of-signal monitors and holdover control for two PLLs
module prs_ref_manager
	import prs_pkg::*;
#(
	parameter int OFS_W = 16,
	parameter int HIST_CYCLES = HIST_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Reference inputs and general-purpose pins
	input wire logic [NREF-1:0] refIn,
	input wire logic [7:0] gpioIn,
	output logic [7:0] gpioOut,
	output logic interrupt_out_n,
	// PLL loop interface
	input wire logic [NPLL*OFS_W-1:0] curOffset,
	output logic [NPLL*OFS_W-1:0] holdOffset,
	output logic [2*NPLL-1:0] pllState,
	output logic [2*NPLL-1:0] selRef,
	output logic [NPLL-1:0] adjFreeze,
	output logic [NPLL-1:0] hitlessSwitch
);
	if (OFS_W < 8 || HIST_CYCLES < 2) begin : g_bad
		$error("prs_ref_manager: OFS_W or HIST_CYCLES too small");
	end
	localparam int HC_W = $clog2(HIST_CYCLES);

	// Priority code of one reference, lower code wins
	function automatic logic [1:0] prioOf(input logic [7:0] pr, input logic [1:0] i);
		return pr[i*2 +: 2];
	endfunction

	// Best valid reference: {found, index}; ties go to the lower index
	function automatic logic [2:0] bestRef(input logic [NREF-1:0] ok, input logic [7:0] pr);
		logic [2:0] r;
		r = 3'h0;
		for (int k = NREF - 1; k >= 0; k--) begin
			if (ok[k] && (!r[2] || pr[k*2 +: 2] <= prioOf(pr, r[1:0]))) begin
				r = {1'b1, 2'(k)};
			end
		end
		return r;
	endfunction

	// Byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	logic [31:0] ctrlQ, prioQ, mapQ, maskQ, evtQ;
	logic [CNT_W-1:0] tgtQ [NREF];
	logic [NREF-1:0] losQ, losPrevQ, softQ;
	logic [2:0] monDivQ;
	logic monEnQ;
	logic [HC_W-1:0] histCntQ;
	logic histTickQ;
	logic [1:0] stQ [NPLL];
	logic [1:0] selQ [NPLL];
	logic [NPLL-1:0] holdEntry;
	logic [31:0] rdData;
	logic [31:0] statWord;
	logic [7:0] gpioD;

	// Bus decode
	wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wrReq = busReq && wb_we_i;
	wire cntSel = wb_adr_i >= A_CNT0 && wb_adr_i < A_MAP && wb_adr_i[1:0] == 2'h0;
	wire [1:0] cntIdx = 2'(wb_adr_i[7:2] - A_CNT0[7:2]);
	wire [NREF-1:0] validRef = ~losQ;
	wire [31:0] evtSet = {{(32 - EVT_HOLD - NPLL){1'b0}}, holdEntry, losQ ^ losPrevQ};
	wire [31:0] evtClr = (wrReq && wb_adr_i == A_EVT) ? merge(32'h0, wb_dat_i, wb_sel_i)
		: 32'h0;

	// Read multiplexer, unmapped addresses read zero
	always_comb begin
		rdData = 32'h0;
		case (wb_adr_i)
			A_CTRL: rdData = ctrlQ;
			A_PRIO: rdData = prioQ;
			A_MAP: rdData = mapQ;
			A_STAT: rdData = statWord;
			A_EVT: rdData = evtQ;
			A_MASK: rdData = maskQ;
			default: rdData = cntSel ? {{(32 - CNT_W){1'b0}}, tgtQ[cntIdx]} : 32'h0;
		endcase
	end

	// Status word
	always_comb begin
		statWord = 32'h0;
		statWord[ST_LOS +: NREF] = losQ;
		statWord[ST_SOFT +: NREF] = softQ;
		statWord[ST_FRZ +: NPLL] = adjFreeze;
		for (int p = 0; p < NPLL; p++) begin
			statWord[ST_STATE + 2*p +: 2] = stQ[p];
			statWord[ST_SEL + 2*p +: 2] = selQ[p];
		end
	end

	// Wishbone slave: one wait-free answer, ack one cycle after the request
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? rdData : 32'h0;
		end
	end

	// Software registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrlQ <= CTRL_RST;
			prioQ <= PRIO_RST;
			mapQ <= MAP_RST;
			maskQ <= 32'h0;
			for (int i = 0; i < NREF; i++) begin
				tgtQ[i] <= CNT_RST;
			end
		end else if (wrReq) begin
			case (wb_adr_i)
				A_CTRL: ctrlQ <= merge(ctrlQ, wb_dat_i, wb_sel_i);
				A_PRIO: prioQ <= merge(prioQ, wb_dat_i, wb_sel_i);
				A_MAP: mapQ <= merge(mapQ, wb_dat_i, wb_sel_i);
				A_MASK: maskQ <= merge(maskQ, wb_dat_i, wb_sel_i);
				default: if (cntSel) begin
					tgtQ[cntIdx] <= CNT_W'(merge({{(32 - CNT_W){1'b0}}, tgtQ[cntIdx]},
						wb_dat_i, wb_sel_i));
				end
			endcase
		end
	end

	// Sticky events, a new event beats a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			evtQ <= 32'h0;
			losPrevQ <= '0;
			interrupt_out_n <= 1'b1;
		end else begin
			evtQ <= (evtQ & ~evtClr) | evtSet;
			losPrevQ <= losQ;
			interrupt_out_n <= ~|(evtQ & maskQ);
		end
	end

	// Routing of loss and holdover flags onto the GPIO outputs
	always_comb begin
		gpioD = 8'h00;
		for (int i = 0; i < NREF; i++) begin
			if (mapQ[i*4 + 3]) begin
				gpioD[mapQ[i*4 +: 3]] = gpioD[mapQ[i*4 +: 3]] | losQ[i];
			end
		end
		for (int p = 0; p < NPLL; p++) begin
			if (mapQ[MAP_HOLD + p*4 + 3]) begin
				gpioD[mapQ[MAP_HOLD + p*4 +: 3]] = gpioD[mapQ[MAP_HOLD + p*4 +: 3]]
					| (stQ[p] == ST_HOLD);
			end
		end
	end

	// Monitor tick and history tick dividers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			monDivQ <= 3'h0;
			monEnQ <= 1'b0;
			histCntQ <= '0;
			histTickQ <= 1'b0;
			gpioOut <= 8'h00;
		end else begin
			monDivQ <= 3'(monDivQ + 3'h1);
			monEnQ <= monDivQ == 3'(MON_DIV - 1);
			histTickQ <= histCntQ == HC_W'(HIST_CYCLES - 1);
			histCntQ <= (histCntQ == HC_W'(HIST_CYCLES - 1)) ? '0 : HC_W'(histCntQ + 1'b1);
			gpioOut <= gpioD;
		end
	end

	// Loss-of-signal monitor, one per reference input
	for (genvar i = 0; i < NREF; i++) begin : g_mon
		logic [2:0] syncQ;
		logic [CNT_W-1:0] cntQ;
		logic [2:0] valQ;
		wire refEdge = syncQ[1] && !syncQ[2];
		wire expire = monEnQ && ({1'b0, cntQ} + 1'b1 >= {1'b0, tgtQ[i]});
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				syncQ <= 3'h0;
				cntQ <= '0;
				valQ <= 3'h0;
				softQ[i] <= 1'b0;
				losQ[i] <= 1'b0;
			end else begin
				syncQ <= {syncQ[1:0], refIn[i]};
				if (refEdge) begin
					cntQ <= '0;
					softQ[i] <= 1'b0;
					valQ <= 3'(valQ + 3'h1);
					if (losQ[i] && valQ == 3'(VAL_EDGES - 1)) begin
						losQ[i] <= 1'b0;
						valQ <= 3'h0;
					end
				end else if (expire) begin
					cntQ <= '0;
					valQ <= 3'h0;
					if (softQ[i]) begin
						losQ[i] <= 1'b1;
					end else begin
						softQ[i] <= 1'b1;
					end
				end else if (monEnQ) begin
					cntQ <= CNT_W'(cntQ + 1'b1);
				end
			end
		end
	end

	// Per-PLL selection, state control and holdover value
	for (genvar p = 0; p < NPLL; p++) begin : g_pll
		prs_cfg_t cfg;
		prs_state_t stD;
		logic [1:0] selD;
		logic signed [OFS_W-1:0] cur, snapAQ, snapBQ, avgQ, holdQ, target;
		logic signed [OFS_W:0] diff, stepv;
		assign cfg = prs_cfg_t'(ctrlQ[p*CFG_STRIDE +: CFG_W]);
		assign cur = curOffset[p*OFS_W +: OFS_W];
		wire [7:0] prio = prioQ[p*PRIO_STRIDE +: 8];
		wire autoMode = cfg.reference_choice_field == MODE_AUTO;
		wire [1:0] manRef = (cfg.reference_choice_field == MODE_PIN) ? gpioIn[2*p +: 2]
			: cfg.manRef;
		wire [2:0] best = bestRef(validRef, prio);
		wire curOk = validRef[selQ[p]];
		wire better = best[2] && prioOf(prio, best[1:0]) < prioOf(prio, selQ[p]);
		assign holdEntry[p] = stQ[p] == ST_LOCK && stD == ST_HOLD;

		// Next state and reference
		always_comb begin
			stD = prs_state_t'(stQ[p]);
			selD = selQ[p];
			if (!autoMode) begin
				if (validRef[manRef]) begin
					stD = ST_LOCK;
					selD = manRef;
				end else if (stQ[p] == ST_LOCK) begin
					stD = ST_HOLD;
				end
			end else if (stQ[p] == ST_LOCK && curOk) begin
				if (cfg.revert && better) begin
					selD = best[1:0];
				end
			end else if (best[2]) begin
				stD = ST_LOCK;
				selD = best[1:0];
			end else if (stQ[p] == ST_LOCK) begin
				stD = ST_HOLD;
			end
		end

		// Holdover target frequency
		always_comb begin
			case (cfg.hoSrc)
				HO_CENTRE: target = '0;
				HO_INST: target = snapBQ;
				HO_AVG: target = avgQ;
				default: target = '0;
			endcase
		end
		assign diff = {target[OFS_W-1], target} - {holdQ[OFS_W-1], holdQ};
		assign stepv = (OFS_W + 1)'(4'h1 << cfg.phase_slope_rate);

		always_ff @(posedge sys_clk) begin
			if (rst) begin
				stQ[p] <= ST_FREE;
				selQ[p] <= 2'h0;
				adjFreeze[p] <= 1'b0;
				hitlessSwitch[p] <= 1'b0;
			end else begin
				stQ[p] <= stD;
				selQ[p] <= selD;
				adjFreeze[p] <= stD == ST_LOCK && softQ[selD];
				hitlessSwitch[p] <= cfg.switch_behaviour_select && (selD != selQ[p]
					|| (stD != stQ[p] && stQ[p] != ST_FREE));
			end
		end

		// History snapshots and IIR average, frozen outside lock
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				snapAQ <= '0;
				snapBQ <= '0;
				avgQ <= '0;
				holdQ <= '0;
			end else begin
				if (histTickQ && stQ[p] == ST_LOCK) begin
					snapAQ <= cur;
					snapBQ <= snapAQ;
					avgQ <= OFS_W'(avgQ + OFS_W'((cur - avgQ) >>> IIR_SHIFT));
				end
				if (stQ[p] != ST_HOLD) begin
					holdQ <= cur;
				end else if (cfg.hoSrc != HO_AVG || cfg.switch_behaviour_select) begin
					holdQ <= target;
				end else if (monEnQ) begin
					if (diff > stepv) begin
						holdQ <= OFS_W'(holdQ + OFS_W'(stepv));
					end else if (diff < -stepv) begin
						holdQ <= OFS_W'(holdQ - OFS_W'(stepv));
					end else begin
						holdQ <= target;
					end
				end
			end
		end
		assign pllState[2*p +: 2] = stQ[p];
		assign selRef[2*p +: 2] = selQ[p];
		assign holdOffset[p*OFS_W +: OFS_W] = holdQ;

		// Checks of the selection state machine
		property p_free_reset;
			@(posedge sys_clk) rst |=> stQ[p] == ST_FREE;
		endproperty
		a_free_reset: assert property (p_free_reset) else $error("not free-run after reset");
		property p_auto_lock;
			@(posedge sys_clk) disable iff (rst)
			autoMode && stQ[p] != ST_LOCK && best[2] |=> stQ[p] == ST_LOCK
				&& selQ[p] == $past(best[1:0]);
		endproperty
		a_auto_lock: assert property (p_auto_lock) else $error("no lock on valid ref");
		property p_to_hold;
			@(posedge sys_clk) disable iff (rst)
			autoMode && stQ[p] == ST_LOCK && !curOk && !best[2] |=> stQ[p] == ST_HOLD;
		endproperty
		a_to_hold: assert property (p_to_hold) else $error("no holdover entry");
		property p_man_hold;
			@(posedge sys_clk) disable iff (rst)
			!autoMode && stQ[p] == ST_LOCK && !validRef[manRef] |=> stQ[p] == ST_HOLD
				&& selQ[p] == $past(selQ[p]);
		endproperty
		a_man_hold: assert property (p_man_hold) else $error("manual did not hold");
		property p_nonrev;
			@(posedge sys_clk) disable iff (rst)
			autoMode && !cfg.revert && stQ[p] == ST_LOCK && curOk |=> $stable(selQ[p]);
		endproperty
		a_nonrev: assert property (p_nonrev) else $error("non-revertive switched");
		property p_hold_stays;
			@(posedge sys_clk) disable iff (rst) stQ[p] == ST_HOLD |=> stQ[p] != ST_FREE;
		endproperty
		a_hold_stays: assert property (p_hold_stays) else $error("hold fell to free");
		property p_hold_alarm;
			@(posedge sys_clk) disable iff (rst)
			holdEntry[p] |=> evtQ[EVT_HOLD + p] ##1 !interrupt_out_n || !maskQ[EVT_HOLD + p];
		endproperty
		a_hold_alarm: assert property (p_hold_alarm) else $error("hold alarm missing");
	end

	// Checks of the monitor timing
	sequence s_gap;
		!monEnQ [*7] ##1 monEnQ;
	endsequence
	property p_mon_rate;
		@(posedge sys_clk) disable iff (rst) monEnQ |=> s_gap;
	endproperty
	a_mon_rate: assert property (p_mon_rate) else $error("monitor tick rate wrong");
	property p_los_second;
		@(posedge sys_clk) disable iff (rst) $rose(losQ[0]) |-> $past(softQ[0]) && softQ[0];
	endproperty
	a_los_second: assert property (p_los_second) else $error("loss without soft alarm");
	property p_edge_restart;
		@(posedge sys_clk) disable iff (rst)
		g_mon[0].refEdge |=> g_mon[0].cntQ == '0 && !softQ[0];
	endproperty
	a_edge_restart: assert property (p_edge_restart) else $error("edge did not restart");
	property p_los_clear;
		@(posedge sys_clk) disable iff (rst)
		$fell(losQ[0]) |-> $past(g_mon[0].valQ) == 3'h7 && $past(g_mon[0].refEdge);
	endproperty
	a_los_clear: assert property (p_los_clear) else $error("loss cleared early");
endmodule

// ### prs_ref_src.sv
// Behavioural model of the four reference clock sources
module prs_ref_src
	import prs_pkg::*;
(
	// Source enables
	input wire logic [NREF-1:0] srcOn,
	// Reference clocks
	output logic [NREF-1:0] refClk
);
	timeunit 1ns;
	timeprecision 1ps;
	// Each source toggles freely while on and rests low once stopped
	for (genvar i = 0; i < NREF; i++) begin : g_src
		logic clkQ = 1'b0;
		initial begin
			forever begin
				#(100 + 4 * i);
				clkQ = srcOn[i] ? ~clkQ : 1'b0;
			end
		end
		assign refClk[i] = clkQ;
	end
endmodule

// ### tb_prs_ref_manager.sv
// Self-checking bench for the reference manager
module tb_prs_ref_manager
	import prs_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OFS = 16;
	localparam int TGT = 8;
	localparam int TC = TGT * MON_DIV;
	logic sysClk = 1'b0;
	logic rst = 1'b1;
	logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatW = 32'h0000_0000, wbDatR, rd;
	logic wbAck, intN;
	logic [NREF-1:0] srcOn = 4'hF, refIn;
	logic [7:0] gpioIn = 8'h00, gpioOut;
	logic [2*OFS-1:0] curOffset = 32'h0000_0000, holdOffset;
	logic [2*NPLL-1:0] pllState, selRef;
	logic [NPLL-1:0] adjFreeze, hitlessSwitch;
	logic [1:0] c;
	logic signed [OFS-1:0] h0, d;
	int fail_count = 0, n_checks = 0, cyc = 0, n, hp;
	// Device under test and the reference sources
	prs_ref_manager #(.OFS_W(OFS), .HIST_CYCLES(16)) dut (.sys_clk(sysClk), .rst(rst),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
		.refIn(refIn), .gpioIn(gpioIn), .gpioOut(gpioOut), .interrupt_out_n(intN),
		.curOffset(curOffset), .holdOffset(holdOffset), .pllState(pllState),
		.selRef(selRef), .adjFreeze(adjFreeze), .hitlessSwitch(hitlessSwitch));
	prs_ref_src src (.srcOn(srcOn), .refClk(refIn));
	// Clock and hang guard
	initial begin
		forever #12.5 sysClk = ~sysClk;
	end
	always @(posedge sysClk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Classic single Wishbone cycle, entered just after a rising edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int k;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= 4'hF;
		wbDatW <= dat;
		for (k = 0; k < 20 && wbAck !== 1'b1; k++) @(posedge sysClk);
		if (k == 20) fail_count++;
		rd = wbDatR;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
		@(posedge sysClk);
	endtask
	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0000_0000);
		chk(rd, exp);
	endtask
	// Highest priority valid input, lower index wins a tie
	function automatic logic [1:0] best(input logic [7:0] pr, input logic [3:0] ok);
		logic [1:0] b;
		logic [2:0] bp;
		b = 2'h0;
		bp = 3'h4;
		for (int i = 0; i < NREF; i++) begin
			if (ok[i] && {1'b0, pr[2*i+:2]} < bp) begin
				b = 2'(i);
				bp = {1'b0, pr[2*i+:2]};
			end
		end
		return b;
	endfunction
	// Main sequence
	initial begin
		void'($urandom(32'h0000_6472));
		repeat (5) @(posedge sysClk);
		chk(pllState, ST_FREE);
		rst <= 1'b0;
		@(posedge sysClk);
		rdchk(A_CTRL, CTRL_RST);
		rdchk(A_PRIO, PRIO_RST);
		for (int i = 0; i < NREF; i++) rdchk(A_CNT0 + 8'(4 * i), 32'(CNT_RST));
		rdchk(A_MAP, MAP_RST);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		rdchk(8'h40, 32'h0000_0000);
		wb(1'b1, A_CNT0, 32'hFFFF_FFFF);
		rdchk(A_CNT0, 32'h0001_FFFF);
		for (int i = 0; i < NREF; i++) wb(1'b1, A_CNT0 + 8'(4 * i), 32'(TGT));
		wb(1'b1, A_MAP, 32'h000D_000C);
		wb(1'b1, A_MASK, 32'h0000_003F);
		wb(1'b1, A_CTRL, 32'h0001_0002);
		$display("test setup done");
		c = 2'($urandom);
		for (int k = 0; k < 4; k++) begin
			gpioIn[3:2] <= c + 2'(k);
			repeat (4) @(posedge sysClk);
			chk(selRef[3:2], 2'(c + 2'(k)));
		end
		gpioIn[3:2] <= 2'h3;
		chk(selRef[1:0], best(8'hE4, 4'hF));
		chk(pllState[1:0], ST_LOCK);
		for (int k = 0; k < 4; k++) begin
			curOffset <= 32'($urandom);
			repeat (2) @(posedge sysClk);
			chk(holdOffset, curOffset);
		end
		$display("test select done");
		srcOn[0] = 1'b0;
		for (n = 0; adjFreeze[0] !== 1'b1 && n < 3000; n++) @(posedge sysClk);
		chk(n >= TC - 2 * MON_DIV && n <= TC + 2 * MON_DIV, 1);
		for (; selRef[1:0] === 2'h0 && n < 3000; n++) @(posedge sysClk);
		chk(n >= 2 * TC - 2 * MON_DIV && n <= 2 * TC + 2 * MON_DIV, 1);
		chk(selRef[1:0], best(8'hE4, 4'hE));
		chk(pllState[1:0], ST_LOCK);
		repeat (2) @(posedge sysClk);
		chk(gpioOut[4], 1);
		chk(intN, 0);
		wb(1'b1, A_MASK, 32'h0000_0000);
		@(posedge sysClk);
		chk(intN, 1);
		wb(1'b1, A_MASK, 32'h0000_003F);
		wb(1'b1, A_EVT, 32'h0000_003F);
		@(posedge sysClk);
		chk(intN, 1);
		$display("test loss done");
		srcOn[1] = 1'b0;
		for (n = 0; adjFreeze[0] !== 1'b1 && n < 3000; n++) @(posedge sysClk);
		chk(adjFreeze[0], 1);
		srcOn[1] = 1'b1;
		for (n = 0; adjFreeze[0] !== 1'b0 && n < 3000; n++) @(posedge sysClk);
		chk(n < 3 * MON_DIV, 1);
		// Loss and stuck soft alarm on input 0, both PLLs locked, FIRST_PLL on 1, PLL1 on 3
		rdchk(A_STAT, 32'h0000_D511);
		$display("test soft done");
		srcOn[0] = 1'b1;
		repeat (40) @(posedge sysClk);
		chk(gpioOut[4], 1);
		repeat (50) @(posedge sysClk);
		chk(gpioOut[4], 0);
		chk(selRef[1:0], 1);
		wb(1'b1, A_CTRL, 32'h0001_0012);
		srcOn[0] = 1'b0;
		for (n = 0; gpioOut[4] !== 1'b1 && n < 3000; n++) @(posedge sysClk);
		chk(gpioOut[4], 1);
		srcOn[0] = 1'b1;
		for (n = 0; selRef[1:0] !== 2'h0 && n < 3000; n++) @(posedge sysClk);
		chk(n >= 7 * MON_DIV && n < 20 * MON_DIV, 1);
		$display("test revert done");
		srcOn = 4'h0;
		for (n = 0; pllState[1:0] !== ST_HOLD && n < 3000; n++) @(posedge sysClk);
		chk(pllState[1:0], ST_HOLD);
		repeat (2) @(posedge sysClk);
		chk(gpioOut[5], 1);
		chk(holdOffset[OFS-1:0], 0);
		wb(1'b0, A_EVT, 32'h0000_0000);
		chk(rd[EVT_HOLD], 1);
		repeat (300) @(posedge sysClk);
		chk(pllState, {ST_HOLD, ST_HOLD});
		srcOn = 4'h6;
		for (n = 0; pllState[1:0] !== ST_LOCK && n < 3000; n++) @(posedge sysClk);
		// Input 2 may validate first; revertive mode then moves to input 1
		repeat (20) @(posedge sysClk);
		chk(pllState[1:0], ST_LOCK);
		chk(selRef[1:0], best(8'hE4, 4'h6));
		chk(pllState[3:2], ST_HOLD);
		$display("test holdover done");
		wb(1'b1, A_CTRL, 32'h0001_0028);
		repeat (4) @(posedge sysClk);
		chk(selRef[1:0], 2);
		hp = 0;
		srcOn[2] = 1'b0;
		for (n = 0; pllState[1:0] !== ST_HOLD && n < 3000; n++) begin
			@(posedge sysClk);
			hp += int'(hitlessSwitch[0]);
		end
		repeat (100) @(posedge sysClk);
		chk(pllState[1:0], ST_HOLD);
		chk(hp, 1);
		$display("test manual done");
		// Snapshot source jumps to the steady offset, average source ramps by one per tick
		wb(1'b1, A_CTRL, 32'h0001_0128);
		repeat (2) @(posedge sysClk);
		chk(holdOffset[OFS-1:0], curOffset[OFS-1:0]);
		wb(1'b1, A_CTRL, 32'h0001_0208);
		h0 = holdOffset[OFS-1:0];
		repeat (80) @(posedge sysClk);
		d = holdOffset[OFS-1:0] - h0;
		chk(d >= -10 && d <= 10 && d != 0, 1);
		$display("test holdover source done");
		end_sim();
	end
endmodule
